/* verilog/iocs_pkg.sv */
// constants for the analog-shared input port and the chip-select port
`default_nettype none
package iocs_pkg;
  // ----------------------------------------------------------------
  // register map (low 16 bits of the address)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_DIRECTION = 16'hffcd; // write-only direction
  localparam logic [15:0] ADDR_LEVELS    = 16'hffce; // analog-shared pin levels
  localparam logic [15:0] ADDR_LATCH     = 16'hffcf; // chip-select port latch
  localparam logic [15:0] ADDR_IRQ_STAT  = 16'hffe8; // sticky request status
  localparam logic [15:0] ADDR_IRQ_MASK  = 16'hffe9; // request mask
  localparam logic [15:0] ADDR_CONTROL   = 16'hffea; // mode / standby / refresh enable
  // ----------------------------------------------------------------
  // reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_RESET_EXP = 8'hf0; // expanded modes
  localparam logic [7:0] DIR_RESET_SC  = 8'he0; // single-chip modes
  localparam logic [7:0] LATCH_RESET   = 8'he0;
  localparam logic [7:0] RSV_ONES      = 8'he0; // bits 7..5 read one
  localparam logic [7:0] ALL_ONES      = 8'hff;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam int         CTL_EXP_BIT   = 0;     // 1 = expanded mode
  localparam int         CTL_SBY_BIT   = 1;     // software standby
  localparam int         CTL_RFE_BIT   = 2;     // refresh pin enable
  localparam logic [2:0] CTL_RESET     = 3'h1;
  localparam int         PORT_W        = 5;
  localparam int         IRQ_W         = 4;
endpackage : iocs_pkg
`default_nettype wire

/* verilog/iocs_ports.sv */
// analog-shared input port and chip-select port with request inputs
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - analog port input-only, level register at FFCE
// - level register reads live pin levels
// - direction register reads back all ones
// - reset/hw standby load direction by mode
// - software standby keeps driven outputs
// - latch register holds five pin outputs
// - read returns latch if output, else pin
// - latch bits seven to five read one
// - reset/hw standby set latch to E0
// - expanded: bits four-one become chip selects
// - single-chip: all pins generic input/output
// - pins three-zero feed interrupt requests always
module iocs_ports
  import iocs_pkg::*;
(
  input  wire logic              ref_clk,         // 20 MHz system clock
  input  wire logic              rst_n,           // async reset, active low
  input  wire logic              hwStandby_n,     // hardware standby, active low
  input  wire logic              expandedMode,    // mode strap, sampled on the first edge after reset release
  input  wire logic [15:0]       regAddr,         // register address
  input  wire logic [7:0]        regWdata,        // write data
  input  wire logic              regWr,           // write strobe
  input  wire logic              regRd,           // read strobe
  output logic      [7:0]        regRdata,        // read data, cycle after strobe
  input  wire logic [7:0]        analogPinIn,     // analog-shared pin levels
  input  wire logic [PORT_W-1:0] csPortIn,        // chip-select port pin levels
  output logic      [PORT_W-1:0] csPortOut,       // pin output values
  output logic      [PORT_W-1:0] csPortOe_n,      // pin output enables, low drives
  input  wire logic [3:0]        memAreaHit,      // bus decoder area hits, active high
  input  wire logic              refreshStrobe,   // refresh controller strobe, active high
  output logic      [IRQ_W-1:0]  external_interrupt_request_n, // requests to controller
  output logic                   irq              // level interrupt
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] dir_q;        // chip_select_port_direction
  logic [PORT_W-1:0] latch_q;      // chip_select_port_latch
  logic [2:0]        ctl_q;        // mode, software standby, refresh enable
  logic [IRQ_W-1:0]  stat_q;       // sticky falling-edge events
  logic [IRQ_W-1:0]  mask_q;       // event mask
  logic [IRQ_W-1:0]  reqPrev_q;    // previous request level
  logic              inReset_q;    // strap capture window
  logic [7:0]        rdata_q;
  logic [PORT_W-1:0] out_q;
  logic [PORT_W-1:0] oe_n_q;
  logic [IRQ_W-1:0]  req_q;
  logic              irq_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic wrDir   = regWr && (regAddr == ADDR_DIRECTION);
  wire logic wrLatch = regWr && (regAddr == ADDR_LATCH);
  wire logic wrStat  = regWr && (regAddr == ADDR_IRQ_STAT);
  wire logic wrMask  = regWr && (regAddr == ADDR_IRQ_MASK);
  wire logic wrCtl   = regWr && (regAddr == ADDR_CONTROL);
  wire logic expNow  = ctl_q[CTL_EXP_BIT];
  wire logic swStby  = ctl_q[CTL_SBY_BIT];
  wire logic rfshEn  = ctl_q[CTL_RFE_BIT] && expNow;
  // hardware standby acts like reset on direction, latch and control, not on status or mask
  wire logic hwInit  = !hwStandby_n;
  // the capture edge must use the strap, since ctl_q still holds its reset mode
  wire logic initExp = inReset_q ? expandedMode : expNow;

  // port read: latch where output, pin where input
  wire logic [PORT_W-1:0] portView = (latch_q & dir_q) | (csPortIn & ~dir_q);

  // ----------------------------------------------------------------
  // pin function per bit
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] pinOut;
  logic [PORT_W-1:0] pinDrive;
  genvar g;
  generate
    for (g = 0; g < PORT_W; g++) begin : gPin
      if (g == 0) begin : gBit0
        // refresh strobe wins over the direction bit
        assign pinOut[g]   = rfshEn ? !refreshStrobe : latch_q[g];
        assign pinDrive[g] = rfshEn | dir_q[g];
      end else begin : gCs
        // bit g carries select (4-g), active low, in expanded mode
        assign pinOut[g]   = expNow ? !memAreaHit[PORT_W-1-g] : latch_q[g];
        assign pinDrive[g] = dir_q[g];
      end
    end
  endgenerate

  // requests track pins regardless of direction or function
  wire logic [IRQ_W-1:0] reqLevel = csPortIn[IRQ_W-1:0];
  wire logic [IRQ_W-1:0] reqFall  = reqPrev_q & ~reqLevel;
  wire logic [IRQ_W-1:0] statNext = (stat_q & ~(wrStat ? regWdata[IRQ_W-1:0] : '0)) | reqFall;

  // read mux, unmapped reads return zero
  logic [7:0] rdMux;
  always_comb begin
    if (regAddr == ADDR_DIRECTION) begin
      rdMux = ALL_ONES;
    end else if (regAddr == ADDR_LEVELS) begin
      rdMux = analogPinIn;
    end else if (regAddr == ADDR_LATCH) begin
      rdMux = RSV_ONES | {3'h0, portView};
    end else if (regAddr == ADDR_IRQ_STAT) begin
      rdMux = {4'h0, stat_q};
    end else if (regAddr == ADDR_IRQ_MASK) begin
      rdMux = {4'h0, mask_q};
    end else if (regAddr == ADDR_CONTROL) begin
      rdMux = {5'h0, ctl_q};
    end else begin
      rdMux = ZERO_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // strap capture and control
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inReset_q <= 1'b1;
      ctl_q     <= CTL_RESET;
    end else if (inReset_q) begin
      // first edge after release latches the mode strap
      inReset_q <= 1'b0;
      ctl_q     <= {2'b00, expandedMode};
    end else if (hwInit) begin
      ctl_q[CTL_SBY_BIT] <= 1'b0;
      ctl_q[CTL_RFE_BIT] <= 1'b0;
    end else if (wrCtl) begin
      // mode is a strap; software sets only standby and refresh enable
      ctl_q[CTL_SBY_BIT] <= regWdata[CTL_SBY_BIT];
      ctl_q[CTL_RFE_BIT] <= regWdata[CTL_RFE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // direction and latch; software standby keeps them, hardware standby reloads them
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q   <= DIR_RESET_SC[PORT_W-1:0];
      latch_q <= LATCH_RESET[PORT_W-1:0];
    end else if (inReset_q || hwInit) begin
      dir_q   <= initExp ? DIR_RESET_EXP[PORT_W-1:0] : DIR_RESET_SC[PORT_W-1:0];
      latch_q <= LATCH_RESET[PORT_W-1:0];
    end else begin
      if (wrDir) begin
        dir_q <= regWdata[PORT_W-1:0];
      end
      if (wrLatch) begin
        latch_q <= regWdata[PORT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // events: set wins over a write-one clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q    <= '0;
      mask_q    <= '0;
      reqPrev_q <= '1;
    end else begin
      reqPrev_q <= reqLevel;
      stat_q    <= statNext;
      if (wrMask) begin
        mask_q <= regWdata[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= ZERO_BYTE;
      out_q   <= '1;
      oe_n_q  <= '1;
      req_q   <= '1;
      irq_q   <= 1'b0;
    end else begin
      rdata_q <= regRd ? rdMux : ZERO_BYTE;
      // software standby freezes driven pins at present value
      if (!swStby) begin
        out_q <= pinOut;
      end
      oe_n_q  <= ~pinDrive;
      req_q   <= reqLevel;
      irq_q   <= |(stat_q & mask_q);
    end
  end

  assign regRdata                     = rdata_q;
  assign csPortOut                    = out_q;
  assign csPortOe_n                   = oe_n_q;
  assign external_interrupt_request_n = req_q;
  assign irq                          = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_dir_reads_ones: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRd && regAddr == ADDR_DIRECTION |=> regRdata == ALL_ONES)
    else $error("direction read not all ones");
  a_levels_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRd && regAddr == ADDR_LEVELS |=> regRdata == $past(analogPinIn))
    else $error("level read not pin value");
  a_latch_view: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRd && regAddr == ADDR_LATCH |=> regRdata[4:0] == $past(portView))
    else $error("latch read mixes wrong");
  a_rsv_ones: assert property (@(posedge ref_clk) disable iff (!rst_n)
    regRd && regAddr == ADDR_LATCH |=> regRdata[7:5] == 3'h7)
    else $error("reserved bits not one");
  a_hw_init: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hwInit && !inReset_q |=> latch_q == LATCH_RESET[PORT_W-1:0])
    else $error("latch not reset by standby");
  a_latch_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wrLatch && !hwInit && !inReset_q |=> latch_q == $past(regWdata[PORT_W-1:0]))
    else $error("latch write lost");
  a_sby_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    swStby && $past(swStby) |=> $stable(csPortOut))
    else $error("output moved in standby");
  a_dram_refresh_strobe_n_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rfshEn |=> !csPortOe_n[0] && ($past(swStby) || csPortOut[0] == !$past(refreshStrobe)))
    else $error("refresh pin not driven");
  a_req_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rst_n |=> external_interrupt_request_n == $past(csPortIn[IRQ_W-1:0]))
    else $error("request not following pin");

  // ----------------------------------------------------------------
  // checks: mode strap, re-init and pin function
  // ----------------------------------------------------------------
  // capture edge: first clock with reset released
  sequence s_strap_edge;
    inReset_q && rst_n;
  endsequence

  // hardware standby outside the capture edge
  sequence s_hw_reinit;
    hwInit && !inReset_q;
  endsequence

  // normal running: no strap capture pending
  sequence s_running;
    rst_n && !inReset_q;
  endsequence

  // the strap of the capture edge picks the direction value
  a_strap_dir: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_strap_edge |=> dir_q == ($past(expandedMode) ? DIR_RESET_EXP[PORT_W-1:0]
                                                    : DIR_RESET_SC[PORT_W-1:0]))
    else $error("direction not loaded from strap");

  a_strap_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_strap_edge |=> latch_q == LATCH_RESET[PORT_W-1:0])
    else $error("latch not loaded after reset");

  // hardware standby keeps the mode and reloads direction
  a_hw_dir: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_hw_reinit |=> dir_q == ($past(expNow) ? DIR_RESET_EXP[PORT_W-1:0]
                                            : DIR_RESET_SC[PORT_W-1:0]))
    else $error("direction not reloaded by standby");

  // software standby must not touch the direction or the latch
  a_sby_regs: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_running ##0 (swStby && !hwInit && !regWr) |=> $stable(dir_q) && $stable(latch_q))
    else $error("standby changed port registers");

  // upper pins: driven exactly where the direction bit is one
  a_pin_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_running |=> csPortOe_n[PORT_W-1:1] == ~$past(dir_q[PORT_W-1:1]))
    else $error("pin enable not following direction");

  // bit zero: direction bit decides unless the refresh strobe owns it
  a_bit0_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_running ##0 !rfshEn |=> csPortOe_n[0] == !$past(dir_q[0]))
    else $error("bit zero enable wrong");

  // expanded: selects on bits four to one, select zero on bit four
  a_cs_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_running ##0 (expNow && !swStby) |=>
      csPortOut[PORT_W-1:1] == ~{$past(memAreaHit[0]), $past(memAreaHit[1]),
                                 $past(memAreaHit[2]), $past(memAreaHit[3])})
    else $error("chip select pins wrong");

  // single-chip: every pin shows its latch bit, no select or strobe
  a_sc_generic: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_running ##0 (!expNow && !swStby) |=> csPortOut == $past(latch_q))
    else $error("single-chip pin not generic");

  // a falling request sets its status bit even under a clear
  a_event_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_running ##0 (|reqFall) |=> (stat_q & $past(reqFall)) == $past(reqFall))
    else $error("request event lost");

  // interrupt line is the registered or of unmasked status
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_running |=> irq == |($past(stat_q) & $past(mask_q)))
    else $error("interrupt level wrong");

endmodule // iocs_ports
`default_nettype wire

/* dv/iocs_pin_model.sv */
// pin-side model of the chip-select port
`timescale 1ns/100ps
`default_nettype none
module iocs_pin_model
  import iocs_pkg::*;
(
  input  wire logic [PORT_W-1:0] csPortOut,  // device pin values
  input  wire logic [PORT_W-1:0] csPortOe_n, // device enables, low drives
  input  wire logic [PORT_W-1:0] extDrive,   // far-side level per pin
  output logic      [PORT_W-1:0] csPortIn    // resolved pin levels
);
  // ----------------
  // wire resolution
  // ----------------
  // a driven pin shows the device value, else the far side level
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      csPortIn[i] = csPortOe_n[i] ? extDrive[i] : csPortOut[i];
    end
  end
endmodule // iocs_pin_model
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the analog-shared and chip-select ports
`timescale 1ns/100ps
`default_nettype none
module tb
  import iocs_pkg::*;
;
  logic ref_clk, rst_n, hwStandby_n, expandedMode, regWr, regRd, refreshStrobe, irq;
  logic [15:0] regAddr;
  logic [7:0]  regWdata, regRdata, analogPinIn;
  logic [PORT_W-1:0] csPortIn, csPortOut, csPortOe_n, extDrive;
  logic [3:0]  memAreaHit, reqN;
  int badCount = 0, nCompared = 0, cycles = 0;
  // ----------------
  // clock, stimulus defaults, timeout
  // ----------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, hwStandby_n, expandedMode, regWr, regRd, refreshStrobe} = 6'b010000;
    {regAddr, regWdata, analogPinIn, extDrive, memAreaHit} = '0;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      endOfTest();
    end
  end
  iocs_ports iocs_ports_inst (.ref_clk(ref_clk), .rst_n(rst_n), .hwStandby_n(hwStandby_n),
    .expandedMode(expandedMode), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .analogPinIn(analogPinIn), .csPortIn(csPortIn),
    .csPortOut(csPortOut), .csPortOe_n(csPortOe_n), .memAreaHit(memAreaHit),
    .refreshStrobe(refreshStrobe), .external_interrupt_request_n(reqN), .irq(irq));
  iocs_pin_model iocs_pin_model_inst (.csPortOut(csPortOut), .csPortOe_n(csPortOe_n),
    .extDrive(extDrive), .csPortIn(csPortIn));
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a; regWdata <= v; regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a; regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    chk(regRdata, exp);
  endtask
  // pins lag register writes by two edges
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic doReset(input logic mode);
    @(posedge ref_clk);
    rst_n <= 1'b0; expandedMode <= mode;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle();
  endtask
  task automatic endOfTest;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic testExpanded;
    extDrive <= 5'h0a; memAreaHit <= 4'b1010;
    doReset(1'b1);
    rdchk(ADDR_DIRECTION, ALL_ONES);
    chk(csPortOe_n, 5'h0f);
    rdchk(ADDR_LATCH, 8'he0 | 8'h0a);
    foreach (analogPinIn[i]) begin
      // writing the read-only level register must not disturb it
      wr(ADDR_LEVELS, 8'h00);
      analogPinIn <= 8'h01 << i;
      rdchk(ADDR_LEVELS, 8'h01 << i);
    end
    wr(ADDR_DIRECTION, 8'h1f); wr(ADDR_LATCH, 8'h0b);
    rdchk(ADDR_LATCH, 8'heb);
    settle();
    chk(csPortOe_n, 5'h00);
    chk(csPortOut, 5'b10101);
    wr(ADDR_LATCH, 8'h00);
    rdchk(ADDR_LATCH, RSV_ONES);
    wr(ADDR_CONTROL, 8'h03); memAreaHit <= 4'hf; settle();
    chk(csPortOut, 5'b10100);
    wr(ADDR_CONTROL, 8'h01); settle();
    chk(csPortOut, 5'h00);
    wr(ADDR_DIRECTION, 8'h00); wr(ADDR_CONTROL, 8'h05); refreshStrobe <= 1'b1; settle();
    chk({csPortOe_n[0], csPortOut[0]}, 2'b00);
    @(posedge ref_clk) refreshStrobe <= 1'b0;
    settle();
    chk({csPortOe_n[0], csPortOut[0]}, 2'b01);
    wr(ADDR_CONTROL, 8'h01); settle();
    chk(csPortOe_n[0], 1'b1);
    rdchk(ADDR_LATCH, 8'hea);
  endtask
  task automatic testStandbyIrq;
    wr(ADDR_DIRECTION, 8'h1f); wr(ADDR_LATCH, 8'h1f);
    hwStandby_n <= 1'b0; repeat (4) @(posedge ref_clk);
    hwStandby_n <= 1'b1; extDrive <= 5'h1f; settle();
    chk(csPortOe_n, 5'h0f);
    rdchk(ADDR_LATCH, 8'hef);
    wr(ADDR_IRQ_STAT, 8'h0f); settle();
    chk(reqN, 4'b1111);
    @(posedge ref_clk) extDrive <= 5'h1d;
    settle();
    chk(reqN, 4'b1101);
    rdchk(ADDR_IRQ_STAT, 8'h02);
    chk(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h02); settle();
    chk(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 8'h02); settle();
    chk(irq, 1'b0);
  endtask
  task automatic testSingleChip;
    doReset(1'b0);
    chk(csPortOe_n, 5'h1f);
    wr(ADDR_DIRECTION, 8'h1f); wr(ADDR_LATCH, 8'h0a);
    wr(ADDR_CONTROL, 8'h04); refreshStrobe <= 1'b1; settle();
    chk(csPortOut, 5'h0a);
    chk(csPortOe_n, 5'h00);
    rdchk(16'h0000, ZERO_BYTE);
  endtask
  initial begin
    testExpanded();
    testStandbyIrq();
    testSingleChip();
    endOfTest();
  end
endmodule // tb
`default_nettype wire
